/* File: core/eei_pkg.sv */
// Purpose: shared constants and types for the event/exception interrupt block
// Assumes: 20 MHz core clock, synchronous active-high reset
// Notes:   vectors are byte addresses of 4-byte slots in page zero
package eei_pkg;

    // source counts
    localparam int unsigned EEI_NUM_EVT     = 9;   // maskable event sources
    localparam int unsigned EEI_NUM_SWI     = 7;   // software interrupts
    localparam int unsigned EEI_NUM_TRAP    = 16;  // trap instructions
    localparam int unsigned EEI_NUM_EXC     = 6;   // reset plus five hw traps
    localparam int unsigned EEI_NUM_TOTAL   = 38;  // all vectored sources

    // priority layout
    localparam int unsigned EEI_PRI_W       = 3;   // implemented field bits
    localparam int unsigned EEI_EPRI_W      = 4;   // effective priority width
    localparam logic [3:0]  EEI_PRI_HI_BIT  = 4'h8; // implied top bit

    // vector addresses
    localparam logic [15:0] EEI_VEC_RESET   = 16'h0000;
    localparam logic [15:0] EEI_VEC_BRK     = 16'h0004;
    localparam logic [15:0] EEI_VEC_TRACE   = 16'h0008;
    localparam logic [15:0] EEI_VEC_STKOVF  = 16'h000c;
    localparam logic [15:0] EEI_VEC_DIV0    = 16'h0010;
    localparam logic [15:0] EEI_VEC_URETI   = 16'h0014;
    localparam logic [15:0] EEI_VEC_TRAP0   = 16'h0040;
    localparam logic [15:0] EEI_VEC_SWI1    = 16'h0100;
    localparam logic [15:0] EEI_VEC_SLOT    = 16'h0004; // bytes per vector

    // event vectors, index = event number (ranking 2..10)
    localparam logic [15:0] EEI_EVT_VEC [EEI_NUM_EVT] = '{
        16'h0080, 16'h0084, 16'h0088, 16'h008c, 16'h0090,
        16'h00a0, 16'h00a4, 16'h00a8, 16'h00ac};
    localparam logic [3:0]  EEI_EVT_RANK [EEI_NUM_EVT] = '{
        4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha};

    // enable register layout: low holds global + events 0..4
    localparam int unsigned EEI_IEL_GLOBAL  = 7;
    localparam int unsigned EEI_IEL_EVTS    = 5;   // events in low register
    localparam logic [7:0]  EEI_IE_RST      = 8'h00;
    localparam logic [7:0]  EEI_PRI_RST     = 8'h00;
    localparam int unsigned EEI_NUM_PRIREG  = 6;

    // register index map on the plain port
    localparam logic [3:0]  EEI_A_IEL       = 4'h0;
    localparam logic [3:0]  EEI_A_IEH       = 4'h1;
    localparam logic [3:0]  EEI_A_PRI0      = 4'h2; // 2..7 priority regs
    localparam logic [3:0]  EEI_A_SWR       = 4'h8; // software requests
    localparam logic [3:0]  EEI_A_SWE       = 4'h9; // software enables
    localparam logic [3:0]  EEI_A_IRQ_STAT  = 4'ha; // sticky status, ro
    localparam logic [3:0]  EEI_A_IRQ_EN    = 4'hb; // status enables
    localparam logic [3:0]  EEI_A_IRQ_CLR   = 4'hc; // write 1 to clear
    localparam logic [3:0]  EEI_A_LEVEL     = 4'hd; // ext int level mode
    localparam logic [3:0]  EEI_A_STATE     = 4'he; // pending event pick and synced pins view
    localparam logic [15:0] EEI_RD_UNMAPPED = 16'h0000;

    // status bit positions
    localparam int unsigned EEI_ST_TAKEN    = 0;
    localparam int unsigned EEI_ST_WAKE     = 1;
    localparam int unsigned EEI_ST_RESET    = 2;
    localparam int unsigned EEI_ST_W        = 3;

    // timing: grant pulse stands one cycle
    localparam real         EEI_CLK_MHZ     = 20.0;
    localparam int unsigned EEI_GRANT_CYC   = 1;

    // kind of vector delivered to the core
    typedef enum logic [2:0] {
        EEI_K_RESET, EEI_K_HWTRAP, EEI_K_SWTRAP, EEI_K_EVENT, EEI_K_SWI
    } eei_kind_e;

    // request/answer toward the core
    typedef struct packed {
        logic            valid;
        eei_kind_e       kind;
        logic [15:0]     vector;
        logic [3:0]      epri;
    } eei_grant_s;

    // plain register port
    typedef struct packed {
        logic            wr;
        logic            rd;
        logic [3:0]      addr;
        logic [15:0]     wdata;
    } eei_reg_req_s;

endpackage : eei_pkg

/* File: core/eei_prio_pick.sv */
// Purpose: picks the best pending event by priority then ranking
// Assumes: inputs from the same clock; purely combinational
// Notes:   lower index equals lower ranking number, served first
module eei_prio_pick
    import eei_pkg::*;
(
    input  wire logic [eei_pkg::EEI_NUM_EVT-1:0] req,
    input  wire logic [3:0]                      epri [eei_pkg::EEI_NUM_EVT],
    input  wire logic [3:0]                      run_pri,
    output logic                                 hit,
    output logic [3:0]                           idx,
    output logic [3:0]                           best
);
    // linear scan: strict greater keeps lower index on ties
    always_comb begin
        hit  = 1'b0;
        idx  = 4'h0;
        best = 4'h0;
        for (int i = 0; i < EEI_NUM_EVT; i++) begin
            // must beat the running level and the best so far
            if (req[i] && epri[i] > run_pri && epri[i] > best) begin
                hit  = 1'b1;
                idx  = 4'(i);
                best = epri[i];
            end
        end
    end
endmodule // eei_prio_pick

/* File: core/eei_ctrl.sv */
// Purpose: event, exception and trap arbitration with vector selection
// Assumes: core sends trap/exception strobes on this clock; event flags
//          come from on-chip peripherals on this clock
// Notes:   grant is a one-cycle pulse; core acks nothing, takes it as-is
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
module eei_ctrl
    import eei_pkg::*;
(
    input  wire logic                            clk,
    input  wire logic                            srst,
    // register port
    input  wire eei_pkg::eei_reg_req_s           reg_req,
    output logic [15:0]                          reg_rdata,
    // peripheral event flags, levels
    input  wire logic [eei_pkg::EEI_NUM_EVT-1:0] evt_flag,
    // raw external interrupt pins, async
    input  wire logic [1:0]                      ext_pin,
    // core side
    input  wire logic [3:0]                      run_pri,
    input  wire logic                            core_busy,
    input  wire logic                            hw_brk,
    input  wire logic                            hw_trace,
    input  wire logic                            hw_stkovf,
    input  wire logic                            hw_div0,
    input  wire logic                            hw_ureti,
    input  wire logic                            sw_trap,
    input  wire logic [3:0]                      sw_trap_num,
    // boot vector control
    input  wire logic                            boot_force,
    input  wire logic [7:0]                      nv_status,
    input  wire logic [15:0]                     boot_vector,
    // power-down
    input  wire logic                            power_down,
    output logic                                 wake_up,
    output eei_pkg::eei_grant_s                  grant,
    output logic                                 irq
);
    import eei_pkg::*;

    // software visible registers
    logic [7:0]             ie_low_q;      // interrupt_enable_low_reg
    logic [7:0]             ie_high_q;     // interrupt_enable_high_reg
    logic [7:0]             pri_q [EEI_NUM_PRIREG]; // priority pairs
    logic [EEI_NUM_SWI-1:0] swr_q;         // software requests
    logic [EEI_NUM_SWI-1:0] swe_q;         // software enables
    logic [1:0]             level_q;       // ext int level-sensitive
    logic [EEI_ST_W-1:0]    stat_q;        // sticky status
    logic [EEI_ST_W-1:0]    stat_en_q;     // status enables
    logic                   rd_pend_q;     // read issued last cycle
    logic [3:0]             rd_addr_q;     // its address
    eei_grant_s             grant_q;       // answer toward core
    logic                   rst_exc_q;     // reset exception pending
    logic [2:0]             ext_s1_q, ext_s2_q, ext_s3_q; // bit 2 unused
    logic                   wake_q;        // wake-up level

    // derived
    logic [EEI_NUM_EVT-1:0] ev_en;         // individual enables
    logic                   global_event_enable;
    logic [3:0]             epri [EEI_NUM_EVT];
    logic [EEI_NUM_EVT-1:0] ev_req;
    logic                   ev_hit;
    logic [3:0]             ev_idx;
    logic [3:0]             ev_best;
    logic                   swi_hit;
    logic [2:0]             swi_idx;
    logic [3:0]             swi_pri;
    logic [1:0]             ext_sync;      // agreed synced pins
    logic                   wr_hit;
    logic [EEI_ST_W-1:0]    stat_set;

    assign global_event_enable = ie_low_q[EEI_IEL_GLOBAL];
    assign ev_en = {ie_high_q[EEI_NUM_EVT-EEI_IEL_EVTS-1:0],
                    ie_low_q[EEI_IEL_EVTS-1:0]};

    // per-event effective priority from its 3-bit field
    for (genvar g = 0; g < EEI_NUM_EVT; g++) begin : g_evt
        localparam int unsigned REG = (g < 5) ? (g / 2) : (g - 5) / 2 + 4;
        localparam int unsigned LO  = (g < 5) ? (g % 2) * 4
                                              : ((g - 5) % 2) * 4;
        logic [EEI_PRI_W-1:0] fld;
        assign fld = (g == 4) ? pri_q[2][EEI_PRI_W-1:0]
                              : pri_q[REG][LO +: EEI_PRI_W];
        // zero stays zero; otherwise top bit implied
        assign epri[g] = (fld == 3'h0) ? 4'h0
                       : (EEI_PRI_HI_BIT | {1'b0, fld});
        assign ev_req[g] = evt_flag[g] && ev_en[g]
                         && global_event_enable && (fld != 3'h0);
    end

    // event arbitration, order follows rankings 2..10
    eei_prio_pick u_pick (
        .req     (ev_req),
        .epri    (epri),
        .run_pri (run_pri),
        .hit     (ev_hit),
        .idx     (ev_idx),
        .best    (ev_best)
    );

    // software interrupts: fixed priority n, highest n wins
    always_comb begin
        swi_hit = 1'b0;
        swi_idx = 3'h0;
        swi_pri = 4'h0;
        for (int i = 0; i < EEI_NUM_SWI; i++) begin
            if (swr_q[i] && swe_q[i] && 4'(i + 1) > run_pri) begin
                swi_hit = 1'b1;
                swi_idx = 3'(i);
                swi_pri = 4'(i + 1);
            end
        end
    end

    // three-stage sync on the pins, change counts when 2nd and 3rd agree
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_s1_q <= 3'h0;
            ext_s2_q <= 3'h0;
            ext_s3_q <= 3'h0;
        end else begin
            ext_s1_q <= {1'b0, ext_pin};
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // hold last agreed level; pins are active low inputs
    logic [1:0] ext_agree_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_agree_q <= 2'h3;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (ext_s2_q[i] == ext_s3_q[i]) begin
                    ext_agree_q[i] <= ext_s3_q[i];
                end
            end
        end
    end
    assign ext_sync = ext_agree_q;

    // wake only for enabled, level-mode external ints (events 0 and 2)
    always_ff @(posedge clk) begin
        if (srst) begin
            wake_q <= 1'b0;
        end else if (!power_down) begin
            wake_q <= 1'b0;                  // leaves with power-down
        end else begin
            wake_q <= (!ext_sync[0] && level_q[0] && ev_en[0]
                       && global_event_enable)
                   || (!ext_sync[1] && level_q[1] && ev_en[2]
                       && global_event_enable);
        end
    end
    assign wake_up = wake_q;

    // reset exception raised on the first cycle after release
    always_ff @(posedge clk) begin
        if (srst) begin
            rst_exc_q <= 1'b1;
        end else if (!core_busy) begin
            rst_exc_q <= 1'b0;
        end
    end

    // grant selection: reset, hw traps, sw traps, then events or swi by priority, event on ties
    always_ff @(posedge clk) begin
        if (srst) begin
            grant_q <= '0;
        end else begin
            grant_q <= '0;                   // pulse, one cycle
            if (!core_busy) begin
                if (rst_exc_q) begin
                    grant_q.valid  <= 1'b1;
                    grant_q.kind   <= EEI_K_RESET;
                    // boot vector overrides reset slot
                    grant_q.vector <= (boot_force || nv_status != 8'h00)
                                    ? boot_vector : EEI_VEC_RESET;
                    grant_q.epri   <= 4'hf;
                end else if (hw_brk) begin
                    grant_q.valid  <= 1'b1;
                    grant_q.kind   <= EEI_K_HWTRAP;
                    grant_q.vector <= EEI_VEC_BRK;
                end else if (hw_trace) begin
                    grant_q.valid  <= 1'b1;
                    grant_q.kind   <= EEI_K_HWTRAP;
                    grant_q.vector <= EEI_VEC_TRACE;
                end else if (hw_stkovf) begin
                    grant_q.valid  <= 1'b1;
                    grant_q.kind   <= EEI_K_HWTRAP;
                    grant_q.vector <= EEI_VEC_STKOVF;
                end else if (hw_div0) begin
                    grant_q.valid  <= 1'b1;
                    grant_q.kind   <= EEI_K_HWTRAP;
                    grant_q.vector <= EEI_VEC_DIV0;
                end else if (hw_ureti) begin
                    grant_q.valid  <= 1'b1;
                    grant_q.kind   <= EEI_K_HWTRAP;
                    grant_q.vector <= EEI_VEC_URETI;
                end else if (sw_trap) begin
                    grant_q.valid  <= 1'b1;
                    grant_q.kind   <= EEI_K_SWTRAP;
                    grant_q.vector <= EEI_VEC_TRAP0
                        + 16'({sw_trap_num, 2'b00});
                end else if (ev_hit && ev_best >= swi_pri) begin
                    grant_q.valid  <= 1'b1;
                    grant_q.kind   <= EEI_K_EVENT;
                    grant_q.vector <= EEI_EVT_VEC[ev_idx];
                    grant_q.epri   <= ev_best;
                end else if (swi_hit) begin
                    grant_q.valid  <= 1'b1;
                    grant_q.kind   <= EEI_K_SWI;
                    grant_q.vector <= EEI_VEC_SWI1
                        + 16'({swi_idx, 2'b00});
                    grant_q.epri   <= swi_pri;
                end
            end
        end
    end
    assign grant = grant_q;

    // software requests: cleared on grant, a write wins
    assign wr_hit = reg_req.wr;
    always_ff @(posedge clk) begin
        if (srst) begin
            swr_q <= '0;
        end else if (wr_hit && reg_req.addr == EEI_A_SWR) begin
            swr_q <= reg_req.wdata[EEI_NUM_SWI-1:0];
        end else if (grant_q.valid && grant_q.kind == EEI_K_SWI) begin
            swr_q[grant_q.vector[4:2]] <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge clk) begin
        if (srst) begin
            ie_low_q  <= EEI_IE_RST;
            ie_high_q <= EEI_IE_RST;
            swe_q     <= '0;
            level_q   <= 2'h0;
            stat_en_q <= '0;
            for (int i = 0; i < EEI_NUM_PRIREG; i++) begin
                pri_q[i] <= EEI_PRI_RST;
            end
        end else if (wr_hit) begin
            case (reg_req.addr)
                EEI_A_IEL:    ie_low_q  <= reg_req.wdata[7:0];
                EEI_A_IEH:    ie_high_q <= reg_req.wdata[7:0];
                EEI_A_SWE:    swe_q     <= reg_req.wdata[EEI_NUM_SWI-1:0];
                EEI_A_LEVEL:  level_q   <= reg_req.wdata[1:0];
                EEI_A_IRQ_EN: stat_en_q <= reg_req.wdata[EEI_ST_W-1:0];
                default: begin
                    // priority block, upper bit of each nibble dropped
                    if (reg_req.addr >= EEI_A_PRI0
                        && reg_req.addr < EEI_A_SWR) begin
                        pri_q[3'(reg_req.addr - EEI_A_PRI0)]
                            <= reg_req.wdata[7:0] & 8'h77;
                    end
                end
            endcase
        end
    end

    // sticky status: set wins over clear
    assign stat_set = {rst_exc_q & !core_busy, wake_q,
                       grant_q.valid};
    always_ff @(posedge clk) begin
        if (srst) begin
            stat_q <= '0;
        end else begin
            stat_q <= (wr_hit && reg_req.addr == EEI_A_IRQ_CLR)
                    ? ((stat_q & ~reg_req.wdata[EEI_ST_W-1:0]) | stat_set)
                    : (stat_q | stat_set);
        end
    end
    assign irq = |(stat_q & stat_en_q);

    // read data stands the cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_pend_q <= 1'b0;
            rd_addr_q <= 4'h0;
        end else begin
            rd_pend_q <= reg_req.rd;
            rd_addr_q <= reg_req.addr;
        end
    end

    always_comb begin
        reg_rdata = EEI_RD_UNMAPPED;
        if (rd_pend_q) begin
            case (rd_addr_q)
                EEI_A_IEL:      reg_rdata = {8'h00, ie_low_q};
                EEI_A_IEH:      reg_rdata = {8'h00, ie_high_q};
                EEI_A_SWR:      reg_rdata = {9'h000, swr_q};
                EEI_A_SWE:      reg_rdata = {9'h000, swe_q};
                EEI_A_IRQ_STAT: reg_rdata = {13'h0000, stat_q};
                EEI_A_IRQ_EN:   reg_rdata = {13'h0000, stat_en_q};
                EEI_A_LEVEL:    reg_rdata = {14'h0000, level_q};
                EEI_A_STATE:    reg_rdata = {3'h0, ev_hit, ev_best,
                                             ev_idx, ext_sync, 2'h0};
                default: begin
                    if (rd_addr_q >= EEI_A_PRI0 && rd_addr_q < EEI_A_SWR) begin
                        reg_rdata = {8'h00,
                                     pri_q[3'(rd_addr_q - EEI_A_PRI0)]};
                    end
                end
            endcase
        end
    end
endmodule // eei_ctrl

/* File: tb/eei_ctrl_chk.sv */
// Purpose: port-level checks on the arbitration block
// Assumes: one clock, srst synchronous and active high
// Notes:   bound to every eei_ctrl instance
module eei_ctrl_chk
    import eei_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  srst,
    input wire eei_pkg::eei_reg_req_s reg_req,
    input wire logic [15:0]           reg_rdata,
    input wire logic [3:0]            run_pri,
    input wire logic                  core_busy,
    input wire logic [3:0]            sw_trap_num,
    input wire logic                  boot_force,
    input wire logic [7:0]            nv_status,
    input wire logic [15:0]           boot_vector,
    input wire logic                  power_down,
    input wire logic                  wake_up,
    input wire eei_pkg::eei_grant_s   grant
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // reset exception shortly after release
    property p_rst_go;
        $fell(srst) && !core_busy |-> ##[1:2]
            (grant.valid && grant.kind == EEI_K_RESET);
    endproperty
    a_rst_go: assert property (p_rst_go) else $error("no reset grant");
    // reset vector, boot override wins
    property p_rst_vec;
        grant.valid && grant.kind == EEI_K_RESET |-> grant.epri == 4'hf
            && grant.vector == ((boot_force || nv_status != 8'h00)
            ? boot_vector : EEI_VEC_RESET);
    endproperty
    a_rst_vec: assert property (p_rst_vec) else $error("bad reset vec");
    // hardware traps only use their five slots
    property p_hw_vec;
        grant.valid && grant.kind == EEI_K_HWTRAP |-> grant.vector inside
            {16'h0004, 16'h0008, 16'h000c, 16'h0010, 16'h0014};
    endproperty
    a_hw_vec: assert property (p_hw_vec) else $error("bad trap vec");
    // trap instruction n lands at 0040 + 4n
    property p_sw_vec;
        grant.valid && grant.kind == EEI_K_SWTRAP |->
            grant.vector == {8'h00, 2'b01, $past(sw_trap_num), 2'b00};
    endproperty
    a_sw_vec: assert property (p_sw_vec) else $error("bad swtrap vec");
    // events only above the running level, top bit implied
    property p_evt_pri;
        grant.valid && grant.kind == EEI_K_EVENT |->
            grant.epri[3] && grant.epri > $past(run_pri);
    endproperty
    a_evt_pri: assert property (p_evt_pri) else $error("event prio");
    // vectors other than reset stay in page zero
    property p_page0;
        grant.valid && grant.kind != EEI_K_RESET |-> grant.vector < 16'h0200;
    endproperty
    a_page0: assert property (p_page0) else $error("vector off page");
    // read data only after a mapped read
    property p_rdata;
        !reg_req.rd || reg_req.addr == 4'hf |=> reg_rdata == EEI_RD_UNMAPPED;
    endproperty
    a_rdata: assert property (p_rdata) else $error("stray read data");
    // no wake outside power-down
    property p_wake;
        !power_down |=> !wake_up;
    endproperty
    a_wake: assert property (p_wake) else $error("wake when awake");
    c_rst: cover property (grant.valid && grant.kind == EEI_K_RESET);
    c_evt: cover property (grant.valid && grant.kind == EEI_K_EVENT);
    c_sw: cover property (grant.valid && grant.kind == EEI_K_SWTRAP);
endmodule // eei_ctrl_chk

bind eei_ctrl eei_ctrl_chk i_chk (.clk, .srst, .reg_req, .reg_rdata,
    .run_pri, .core_busy, .sw_trap_num, .boot_force, .nv_status,
    .boot_vector, .power_down, .wake_up, .grant);

/* File: tb/eei_core_model.sv */
// Purpose: behavioural core taking vectors from the block
// Assumes: grant is a one-cycle pulse
// Notes:   busy is combinational so a held trap is not taken twice
module eei_core_model
    import eei_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire eei_pkg::eei_grant_s grant,
    input  wire logic                return_from_interrupt,
    output logic [3:0]               run_pri,
    output logic                     core_busy
);
    logic [1:0] busy_q; // vector fetch cycles left
    assign core_busy = grant.valid || (busy_q != 2'h0);
    // vector fetch window
    always_ff @(posedge clk) begin
        if (srst) busy_q <= 2'h0;
        else if (grant.valid) busy_q <= 2'h2;
        else if (busy_q != 2'h0) busy_q <= busy_q - 2'h1;
    end
    // event handler runs at granted level until return
    always_ff @(posedge clk) begin
        if (srst || return_from_interrupt) run_pri <= 4'h0;
        else if (grant.valid && grant.kind == EEI_K_EVENT) begin
            run_pri <= grant.epri;
        end
    end
endmodule // eei_core_model

/* File: tb/eei_ctrl_tb.sv */
// Purpose: self-checking bench for the arbitration block
// Assumes: 20 MHz clock, reset held two cycles
// Notes:   core side answered by eei_core_model
module eei_ctrl_tb import eei_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic         clk = 1'b0;
    logic         srst = 1'b1;
    eei_reg_req_s req = '0;         // register port
    logic [15:0]  rdata;
    logic [8:0]   evt_flag = '0;    // peripheral levels
    logic [1:0]   ext_pin = 2'b11;  // active low pins
    logic [4:0]   hw = '0;          // brk trace stkovf div0 ureti
    logic         sw_trap = 1'b0;
    logic [3:0]   sw_num = 4'h0;
    logic         boot_force = 1'b0;
    logic [7:0]   nv_status = 8'h00;
    logic         power_down = 1'b0;
    logic         return_from_interrupt = 1'b0;
    logic [3:0]   run_pri;
    logic         core_busy, wake_up, irq;
    eei_grant_s   grant, g;         // live and last caught grant
    int           failures = 0;
    int           n_checks = 0;
    localparam logic [15:0] BOOT_VEC = 16'h1230; // any boot address
    always #25 clk = ~clk;
    eei_ctrl i_dut (.clk, .srst, .reg_req(req), .reg_rdata(rdata),
        .evt_flag, .ext_pin, .run_pri, .core_busy, .hw_brk(hw[0]),
        .hw_trace(hw[1]), .hw_stkovf(hw[2]), .hw_div0(hw[3]),
        .hw_ureti(hw[4]), .sw_trap, .sw_trap_num(sw_num), .boot_force,
        .nv_status, .boot_vector(BOOT_VEC), .power_down, .wake_up,
        .grant, .irq);
    eei_core_model i_core (.clk, .srst, .grant, .return_from_interrupt, .run_pri,
        .core_busy);
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge clk) req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) req.wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [15:0] exp, string what);
        @(posedge clk) req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk) req.rd <= 1'b0;
        @(negedge clk) check(what, rdata, exp);
    endtask
    // bounded wait for the next grant pulse
    task automatic wait_grant();
        g = '0;
        for (int i = 0; i < 12 && !g.valid; i++) begin
            @(negedge clk);
            if (grant.valid === 1'b1) g = grant;
        end
        check("grant", {15'h0, g.valid}, 16'h0001);
    endtask
    task automatic no_grant(string what);
        int seen = 0;
        repeat (5) @(negedge clk) if (grant.valid !== 1'b0) seen++;
        check(what, 16'(seen), 16'h0000);
    endtask
    // handler return, optionally dropping a served flag
    task automatic ret(int f);
        @(posedge clk) return_from_interrupt <= 1'b1;
        if (f >= 0) evt_flag[f] <= 1'b0;
        @(posedge clk) return_from_interrupt <= 1'b0;
    endtask
    task automatic t_reset();
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) srst <= 1'b1;
            boot_force <= (i == 1);
            nv_status <= (i == 2) ? 8'h01 : 8'h00;
            repeat (2) @(posedge clk);
            srst <= 1'b0;
            wait_grant();
            check("rst vec", g.vector, i ? BOOT_VEC : EEI_VEC_RESET);
            check("rst kind", {13'h0, g.kind}, 16'h0000);
        end
        @(posedge clk) boot_force <= 1'b0;
        nv_status <= 8'h00;
    endtask
    task automatic t_event();
        wr(EEI_A_IEL, 16'h0081);
        wr(EEI_A_PRI0, 16'h000b);   // bit 3 is not kept
        @(posedge clk) evt_flag[0] <= 1'b1;
        wait_grant();
        check("evt vec", g.vector, 16'h0080);
        check("evt pri", {12'h0, g.epri}, 16'h000b);
        no_grant("own level");
        wr(EEI_A_PRI0, 16'h0000);
        ret(-1);
        no_grant("field zero");
        wr(EEI_A_IEL, 16'h0001);
        wr(EEI_A_PRI0, 16'h0001);
        no_grant("global off");
        @(posedge clk) evt_flag[0] <= 1'b0;
    endtask
    task automatic t_rank();
        wr(EEI_A_IEH, 16'h000f);
        wr(EEI_A_IEL, 16'h0080);
        wr(EEI_A_PRI0 + 4'h4, 16'h0022);
        wr(EEI_A_PRI0 + 4'h5, 16'h0022);
        @(posedge clk) evt_flag[8:5] <= 4'hf;
        for (int i = 0; i < 4; i++) begin
            wait_grant();
            check("rank vec", g.vector, 16'h00a0 + 16'(4 * i));
            check("rank pri", {12'h0, g.epri}, 16'h000a);
            ret(5 + i);
        end
    endtask
    task automatic t_traps();
        for (int i = 0; i < 21; i++) begin
            @(posedge clk) if (i < 5) hw[i] <= 1'b1;
            else {sw_trap, sw_num} <= {1'b1, 4'(i - 5)};
            wait_grant();
            @(posedge clk) {hw, sw_trap} <= '0;
            check("trap vec", g.vector, (i < 5) ? 16'(4 + 4 * i)
                : EEI_VEC_TRAP0 + 16'(4 * (i - 5)));
        end
    endtask
    task automatic t_irq();
        wr(EEI_A_IRQ_CLR, 16'h0007);
        wr(EEI_A_IRQ_STAT, 16'h0007);   // read-only, ignored
        rd(EEI_A_IRQ_STAT, 16'h0000, "status clr");
        rd(4'hf, EEI_RD_UNMAPPED, "unmapped");
        wr(EEI_A_SWE, 16'h0004);
        wr(EEI_A_SWR, 16'h0004);
        wait_grant();
        check("swi vec", g.vector, 16'h0108);
        rd(EEI_A_SWR, 16'h0000, "swi done");
        @(negedge clk) check("irq masked", {15'h0, irq}, 16'h0000);
        rd(EEI_A_IRQ_STAT, 16'h0001, "status taken");
        wr(EEI_A_IRQ_EN, 16'h0001);
        @(negedge clk) check("irq on", {15'h0, irq}, 16'h0001);
        wr(EEI_A_IRQ_CLR, 16'h0001);
        @(negedge clk) check("irq off", {15'h0, irq}, 16'h0000);
    endtask
    task automatic t_wake();
        wr(EEI_A_IEL, 16'h0081);
        for (int m = 1; m >= 0; m--) begin
            wr(EEI_A_LEVEL, 16'(m));
            @(posedge clk) {power_down, ext_pin} <= 3'b110;
            repeat (8) @(negedge clk);
            check("wake", {15'h0, wake_up}, 16'(m));
            @(posedge clk) {power_down, ext_pin} <= 3'b011;
        end
        ret(-1);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // run needs well under 2000 cycles
    initial begin
        repeat (4000) @(posedge clk);
        failures++;
        close_out();
    end
    initial begin
        t_reset();
        t_event();
        t_rank();
        t_traps();
        t_irq();
        t_wake();
        close_out();
    end
endmodule // eei_ctrl_tb
